// ==== pde_pad_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Board-side pad model: resolves the level seen on each pin
// ****************************************************************
module pde_pad_model (
	input wire logic mclk_in,
	input wire logic [7:0] pad_out_in,  // Strong driver value
	input wire logic [7:0] pad_oe_in,  // Strong driver enable
	input wire logic [7:0] pull_up_in,  // Resistive pull-up
	input wire logic [7:0] pull_down_in,  // Resistive pull-down
	input wire logic [7:0] ext_oe_in,  // Board driver enable
	input wire logic [7:0] ext_val_in,  // Board driver value
	output logic [7:0] level_out  // Resolved pin level
);
	logic [7:0] last_r;  // Level of the previous cycle

	// Board driver wins; a floating pin toggles so a stale value never reads back
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			level_out[i] = ext_oe_in[i] ? ext_val_in[i] : pad_oe_in[i] ? pad_out_in[i] :
				pull_up_in[i] ? 1'b1 : pull_down_in[i] ? 1'b0 : ~last_r[i];
		end
	end

	// Remember the level for the floating case
	always_ff @(posedge mclk_in) begin
		last_r <= level_out;
	end
endmodule : pde_pad_model
`default_nettype wire

// ==== pde_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Two-stage synchroniser with edge detection for one pin
// ****************************************************************
module pde_pin_sync (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic pin_in,
	output logic level_out,
	output logic rise_out,
	output logic fall_out
);
	logic meta_r;  // First stage, read only by the second stage
	logic sync_r;  // Second stage, safe to use
	logic prev_r;  // Previous synced level for edge detection

	// Synchronise and delay once for the edge compare
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= pin_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign level_out = sync_r;
	assign rise_out = sync_r & ~prev_r;
	assign fall_out = ~sync_r & prev_r;
endmodule : pde_pin_sync
`default_nettype wire

// ==== pde_pkg.sv ====
// ****************************************************************
// Shared constants for the port pin drive and edge interrupt block
// ****************************************************************
package pde_pkg;

	// ****************************************************************
	// Port geometry
	// ****************************************************************
	localparam int PDE_PINS = 8;  // Pins in one port
	localparam int PDE_AW = 5;  // Register address width
	localparam int PDE_USB_LO = 6;  // Lowest usb-capable pin index
	localparam int PDE_USB_HI = 7;  // Highest usb-capable pin index

	// ****************************************************************
	// Register offsets, port form (one bit per pin)
	// ****************************************************************
	localparam logic [4:0] PDE_OFS_OUTPUT_VALUE = 5'h00;  // Output value register
	localparam logic [4:0] PDE_OFS_PIN_STATE = 5'h01;  // Pin-state readback, read only
	localparam logic [4:0] PDE_OFS_DRIVE_BIT0 = 5'h02;  // Drive select bit 0
	localparam logic [4:0] PDE_OFS_DRIVE_BIT1 = 5'h03;  // Drive select bit 1
	localparam logic [4:0] PDE_OFS_DRIVE_BIT2 = 5'h04;  // Drive select bit 2
	localparam logic [4:0] PDE_OFS_HW_OUT_SEL = 5'h05;  // Fabric drives the output
	localparam logic [4:0] PDE_OFS_IN_ENABLE = 5'h06;  // Input forwarded to fabric
	localparam logic [4:0] PDE_OFS_IRQ_RISE = 5'h07;  // Rising-edge interrupt enable
	localparam logic [4:0] PDE_OFS_IRQ_FALL = 5'h08;  // Falling-edge interrupt enable
	localparam logic [4:0] PDE_OFS_IRQ_STATUS = 5'h09;  // Sticky status, cleared by read
	localparam logic [4:0] PDE_OFS_PIN_BASE = 5'h10;  // Pin form, one register per pin

	// ****************************************************************
	// Pin-form field positions
	// ****************************************************************
	localparam int PDE_PF_OUT = 0;  // Output value
	localparam int PDE_PF_DM_LO = 1;  // Drive select, low bit
	localparam int PDE_PF_BYP = 4;  // Hardware output select
	localparam int PDE_PF_INEN = 5;  // Input to fabric enable
	localparam int PDE_PF_RISE = 6;  // Rising-edge interrupt
	localparam int PDE_PF_FALL = 7;  // Falling-edge interrupt

	// ****************************************************************
	// Drive select codes
	// ****************************************************************
	localparam logic [2:0] PDE_DM_HIZ_ANALOG = 3'h0;
	localparam logic [2:0] PDE_DM_HIZ_DIGITAL = 3'h1;
	localparam logic [2:0] PDE_DM_RES_UP = 3'h2;
	localparam logic [2:0] PDE_DM_RES_DOWN = 3'h3;
	localparam logic [2:0] PDE_DM_OD_LOW = 3'h4;
	localparam logic [2:0] PDE_DM_OD_HIGH = 3'h5;
	localparam logic [2:0] PDE_DM_STRONG = 3'h6;
	localparam logic [2:0] PDE_DM_RES_BOTH = 3'h7;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] PDE_RST_BYTE = 8'h00;  // Data, enables and status
	localparam logic [2:0] PDE_RST_DM = 3'h0;  // Drive select before the strap load

endpackage : pde_pkg

// ==== pde_port.sv ====
// Function
// - Each pin owns a three-bit drive select
// - Codes 0,1,2,3,6 drive as tabled
// - Codes 4,5 are open drain low/high
// - Code 7 pulls up or down resistively
// - Output from fabric or output register
// - Input updates readback and optionally fabric
// - Separate readback and output value registers
// - Rising, falling or both-edge interrupts
// - One interrupt request line per port
// - Only edge interrupts, no level mode
// - Settings reachable per port and per pin
// - Drive select of pins 0..5 loaded from reset strap
// - Usb pins: drive enable gives strong
// - Usb pins: pull enable gives resistive up
// - Usb mode ignores usb pin drive bits
// - Port writes never touch usb pin drive
// - Event sets status bit and request
`timescale 1ns/1ps
`default_nettype none
module pde_port
	import pde_pkg::*;
(
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic [4:0] addr_in,  // Register address
	input wire logic [7:0] wdata_in,  // Write data
	input wire logic wr_in,  // Write strobe
	input wire logic rd_in,  // Read strobe
	output logic [7:0] rdata_out,  // Read data, cycle after the strobe
	input wire logic [2:0] init_drive_select_in,  // Programmed reset drive select
	input wire logic usb_mode_in,  // Usb pins owned by the usb core
	input wire logic [7:0] pad_in,  // Sensed pin levels
	input wire logic [7:0] fabric_out_in,  // Fabric output signals
	output logic [7:0] fabric_in_out,  // Pin levels toward the fabric
	output logic [7:0] pad_out,  // Strongly driven value
	output logic [7:0] pad_oe_out,  // Strong driver enable
	output logic [7:0] pull_up_out,  // Resistive pull-up enable
	output logic [7:0] pull_down_out,  // Resistive pull-down enable
	output logic irq_out  // Port interrupt request
);
	// ****************************************************************
	// Storage
	// ****************************************************************
	logic [7:0] out_val_r;  // Output value register
	logic [7:0] pin_state_r;  // Pin-state readback
	logic [2:0] drive_sel_r [PDE_PINS];  // Drive select per pin
	logic [7:0] hw_sel_r;  // Fabric drives output when set
	logic [7:0] in_en_r;  // Forward input to fabric when set
	logic [7:0] rise_en_r;  // Rising-edge interrupt enable
	logic [7:0] fall_en_r;  // Falling-edge interrupt enable
	logic [7:0] status_r;  // Sticky interrupt status
	logic [7:0] rdata_r;  // Registered read data
	logic irq_r;  // Registered request
	logic strap_pend_r;  // Strap load still owed after reset
	logic [7:0] drv_r, oe_r, pu_r, pd_r;  // Registered pad controls

	// ****************************************************************
	// Combinational helpers
	// ****************************************************************
	logic [7:0] sync_lvl, sync_rise, sync_fall;  // Synced levels and edges
	logic [7:0] event_hit;  // Configured edge this cycle
	logic [7:0] status_nxt;  // Next status
	logic [7:0] out_src;  // Output value after source select
	logic [7:0] drv_nxt, oe_nxt, pu_nxt, pd_nxt;  // Next pad controls
	logic [7:0] rdata_nxt;  // Next read data
	logic pin_hit;  // Access lands in the pin-form window
	logic [2:0] pin_idx;  // Pin addressed in pin form
	logic stat_rd;  // Status register read this cycle

	assign pin_hit = (addr_in[4:3] == PDE_OFS_PIN_BASE[4:3]);
	assign pin_idx = addr_in[2:0];
	assign stat_rd = rd_in && (addr_in == PDE_OFS_IRQ_STATUS);

	// ****************************************************************
	// Input synchronisers, one per pin
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < PDE_PINS; gi++) begin : g_sync
			// Two flops ahead of edge detection and readback
			pde_pin_sync u_sync (
				.mclk_in(mclk_in),
				.arst_n_in(arst_n_in),
				.pin_in(pad_in[gi]),
				.level_out(sync_lvl[gi]),
				.rise_out(sync_rise[gi]),
				.fall_out(sync_fall[gi])
			);
		end
	endgenerate

	// ****************************************************************
	// Input path
	// ****************************************************************
	// Readback always follows the pin; fabric sees it only when enabled
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pin_state_r <= PDE_RST_BYTE;
			fabric_in_out <= PDE_RST_BYTE;
		end else begin
			pin_state_r <= sync_lvl;
			fabric_in_out <= sync_lvl & in_en_r;
		end
	end

	// ****************************************************************
	// Port-form and pin-form control registers
	// ****************************************************************
	// A pin-form write lands on the same flops as the port form, so both views agree
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			out_val_r <= PDE_RST_BYTE;
			hw_sel_r <= PDE_RST_BYTE;
			in_en_r <= PDE_RST_BYTE;
			rise_en_r <= PDE_RST_BYTE;
			fall_en_r <= PDE_RST_BYTE;
		end else if (wr_in) begin
			case (addr_in)
				PDE_OFS_OUTPUT_VALUE: out_val_r <= wdata_in;
				PDE_OFS_HW_OUT_SEL: hw_sel_r <= wdata_in;
				PDE_OFS_IN_ENABLE: in_en_r <= wdata_in;
				PDE_OFS_IRQ_RISE: rise_en_r <= wdata_in;
				PDE_OFS_IRQ_FALL: fall_en_r <= wdata_in;
				default: begin
					// Pin form: one register gathers this pin's bits
					if (pin_hit) begin
						out_val_r[pin_idx] <= wdata_in[PDE_PF_OUT];
						hw_sel_r[pin_idx] <= wdata_in[PDE_PF_BYP];
						in_en_r[pin_idx] <= wdata_in[PDE_PF_INEN];
						rise_en_r[pin_idx] <= wdata_in[PDE_PF_RISE];
						fall_en_r[pin_idx] <= wdata_in[PDE_PF_FALL];
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// Drive select storage
	// ****************************************************************
	// Flops reset to a constant; the strap is sampled on the first edge after release
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			strap_pend_r <= 1'b1;
			for (int i = 0; i < PDE_PINS; i++) begin
				drive_sel_r[i] <= PDE_RST_DM;
			end
		end else if (strap_pend_r) begin
			strap_pend_r <= 1'b0;
			// Usb pins keep the constant, which reads as open drain
			for (int i = 0; i < PDE_USB_LO; i++) begin
				drive_sel_r[i] <= init_drive_select_in;
			end
		end else if (wr_in) begin
			if (pin_hit) begin
				// Per-pin write is the only path into usb pin drive bits
				drive_sel_r[pin_idx] <= wdata_in[PDE_PF_DM_LO +: 3];
			end else begin
				// Port-wide writes skip the usb-capable pins
				for (int i = 0; i < PDE_USB_LO; i++) begin
					case (addr_in)
						PDE_OFS_DRIVE_BIT0: drive_sel_r[i][0] <= wdata_in[i];
						PDE_OFS_DRIVE_BIT1: drive_sel_r[i][1] <= wdata_in[i];
						PDE_OFS_DRIVE_BIT2: drive_sel_r[i][2] <= wdata_in[i];
						default: drive_sel_r[i] <= drive_sel_r[i];
					endcase
				end
			end
		end
	end

	// ****************************************************************
	// Output value source and drive decode
	// ****************************************************************
	// Decode chosen for all eight codes; usb pins use only bits 1:0
	always_comb begin
		out_src = (hw_sel_r & fabric_out_in) | (~hw_sel_r & out_val_r);
		drv_nxt = 8'h00;
		oe_nxt = 8'h00;
		pu_nxt = 8'h00;
		pd_nxt = 8'h00;
		for (int i = 0; i < PDE_PINS; i++) begin
			drv_nxt[i] = out_src[i];
			if (i >= PDE_USB_LO) begin
				if (usb_mode_in) begin
					// Usb core owns the pads; drive bits are ignored
					oe_nxt[i] = 1'b0;
				end else if (drive_sel_r[i][0]) begin
					oe_nxt[i] = 1'b1;
				end else begin
					// Low is always strong; high floats or pulls up
					oe_nxt[i] = ~out_src[i];
					pu_nxt[i] = out_src[i] & drive_sel_r[i][1];
				end
			end else begin
				case (drive_sel_r[i])
					PDE_DM_HIZ_ANALOG, PDE_DM_HIZ_DIGITAL: oe_nxt[i] = 1'b0;
					PDE_DM_RES_UP: begin
						oe_nxt[i] = ~out_src[i];
						pu_nxt[i] = out_src[i];
					end
					PDE_DM_RES_DOWN: begin
						oe_nxt[i] = out_src[i];
						pd_nxt[i] = ~out_src[i];
					end
					PDE_DM_OD_LOW: oe_nxt[i] = ~out_src[i];
					PDE_DM_OD_HIGH: oe_nxt[i] = out_src[i];
					PDE_DM_STRONG: oe_nxt[i] = 1'b1;
					PDE_DM_RES_BOTH: begin
						pu_nxt[i] = out_src[i];
						pd_nxt[i] = ~out_src[i];
					end
					default: oe_nxt[i] = 1'b0;
				endcase
			end
		end
	end

	// Register pad controls so each output comes from a flop
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			drv_r <= PDE_RST_BYTE;
			oe_r <= PDE_RST_BYTE;
			pu_r <= PDE_RST_BYTE;
			pd_r <= PDE_RST_BYTE;
		end else begin
			drv_r <= drv_nxt;
			oe_r <= oe_nxt;
			pu_r <= pu_nxt;
			pd_r <= pd_nxt;
		end
	end

	assign pad_out = drv_r;
	assign pad_oe_out = oe_r;
	assign pull_up_out = pu_r;
	assign pull_down_out = pd_r;

	// ****************************************************************
	// Edge interrupts
	// ****************************************************************
	// Edges only; level behaviour has to be built in the fabric
	always_comb begin
		event_hit = (sync_rise & rise_en_r) | (sync_fall & fall_en_r);
		// A new edge wins over the clearing read
		status_nxt = (stat_rd ? 8'h00 : status_r) | event_hit;
	end

	// Sticky status and one request line for the whole port
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			status_r <= PDE_RST_BYTE;
			irq_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			irq_r <= |status_nxt;
		end
	end

	assign irq_out = irq_r;

	// ****************************************************************
	// Read path
	// ****************************************************************
	// Readback and output value live at separate offsets
	always_comb begin
		rdata_nxt = 8'h00;
		case (addr_in)
			PDE_OFS_OUTPUT_VALUE: rdata_nxt = out_val_r;
			PDE_OFS_PIN_STATE: rdata_nxt = pin_state_r;
			PDE_OFS_DRIVE_BIT0: for (int i = 0; i < PDE_PINS; i++) rdata_nxt[i] = drive_sel_r[i][0];
			PDE_OFS_DRIVE_BIT1: for (int i = 0; i < PDE_PINS; i++) rdata_nxt[i] = drive_sel_r[i][1];
			PDE_OFS_DRIVE_BIT2: for (int i = 0; i < PDE_PINS; i++) rdata_nxt[i] = drive_sel_r[i][2];
			PDE_OFS_HW_OUT_SEL: rdata_nxt = hw_sel_r;
			PDE_OFS_IN_ENABLE: rdata_nxt = in_en_r;
			PDE_OFS_IRQ_RISE: rdata_nxt = rise_en_r;
			PDE_OFS_IRQ_FALL: rdata_nxt = fall_en_r;
			PDE_OFS_IRQ_STATUS: rdata_nxt = status_r;
			default: begin
				if (pin_hit) begin
					rdata_nxt[PDE_PF_OUT] = out_val_r[pin_idx];
					rdata_nxt[PDE_PF_DM_LO +: 3] = drive_sel_r[pin_idx];
					rdata_nxt[PDE_PF_BYP] = hw_sel_r[pin_idx];
					rdata_nxt[PDE_PF_INEN] = in_en_r[pin_idx];
					rdata_nxt[PDE_PF_RISE] = rise_en_r[pin_idx];
					rdata_nxt[PDE_PF_FALL] = fall_en_r[pin_idx];
				end
			end
		endcase
	end

	// Data stand only in the cycle after the strobe; unmapped reads give zero
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_r <= PDE_RST_BYTE;
		end else begin
			rdata_r <= rd_in ? rdata_nxt : 8'h00;
		end
	end

	assign rdata_out = rdata_r;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_irq_status_link: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
		irq_out == (|status_r)) else $error("request does not match status");
	a_edge_sets_status: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
		(sync_rise[0] && rise_en_r[0]) |=> status_r[0] && irq_out) else $error("rising edge lost");
	a_read_clears_status: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
		(stat_rd && event_hit == 8'h00) |=> status_r == 8'h00) else $error("status not cleared by read");
	a_no_level_irq: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
		(status_r == 8'h00 && $stable(sync_lvl) && $stable(pad_in)) ##1 $stable(sync_lvl)
		|=> status_r == 8'h00) else $error("status set without an edge");
	a_readback_sync: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
		$rose(pad_in[1]) ##1 pad_in[1] [*3] |=> pin_state_r[1]) else $error("readback stale");
	a_strong_drive: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
		drive_sel_r[0] == PDE_DM_STRONG |=> pad_oe_out[0] && !pull_up_out[0]) else $error("strong mode not driving");
	a_open_drain_low: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
		(drive_sel_r[2] == PDE_DM_OD_LOW && out_src[2]) |=> !pad_oe_out[2]) else $error("open drain drove high");
	a_res_both: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
		drive_sel_r[3] == PDE_DM_RES_BOTH |=> !pad_oe_out[3] && (pull_up_out[3] != pull_down_out[3]))
		else $error("resistive both mode wrong");
	a_usb_mode_off: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
		usb_mode_in |=> !pad_oe_out[7] && !pull_up_out[7]) else $error("usb pin driven in usb mode");
	a_port_keeps_usb: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
		(wr_in && !pin_hit && !strap_pend_r) |=> $stable(drive_sel_r[6]) && $stable(drive_sel_r[7]))
		else $error("port write changed usb drive");
	a_hw_out_source: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
		hw_sel_r[0] |=> pad_out[0] == $past(fabric_out_in[0])) else $error("fabric value not used");
	a_read_one_cycle: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
		(rd_in && addr_in == PDE_OFS_PIN_STATE) |=> rdata_out == $past(pin_state_r)) else $error("readback wrong");
endmodule : pde_port
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Self-checking bench for the port block
// ****************************************************************
module testbench;
	import pde_pkg::*;
	logic mclk_in = 1'b0;  // System clock
	logic arst_n_in = 1'b0;  // Reset, active low
	logic [4:0] addr_in = 5'h00;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic usb_mode_in = 1'b0;  // Usb pins left to the port at first
	logic [7:0] fabric_out_in = 8'h00;
	logic [7:0] ext_oe = 8'h00;  // Board drives nothing at first
	logic [7:0] ext_val = 8'h00;
	logic [7:0] rdata_out, pad_in, fabric_in_out, pad_out, pad_oe_out, pull_up_out, pull_down_out;
	logic irq_out;
	int error_cnt = 0;
	int compares = 0;

	always #5 mclk_in = ~mclk_in;  // 100 MHz

	pde_port dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .init_drive_select_in(3'h6),
		.usb_mode_in(usb_mode_in), .pad_in(pad_in), .fabric_out_in(fabric_out_in),
		.fabric_in_out(fabric_in_out), .pad_out(pad_out), .pad_oe_out(pad_oe_out),
		.pull_up_out(pull_up_out), .pull_down_out(pull_down_out), .irq_out(irq_out));

	pde_pad_model board (.mclk_in(mclk_in), .pad_out_in(pad_out), .pad_oe_in(pad_oe_out),
		.pull_up_in(pull_up_out), .pull_down_in(pull_down_out), .ext_oe_in(ext_oe),
		.ext_val_in(ext_val), .level_out(pad_in));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Expected {enable, high, pull-up, pull-down} of a general pin
	function automatic logic [3:0] exp_gp(input logic [2:0] c, input logic v);
		case (c)
			3'h2: return v ? 4'h2 : 4'h8;
			3'h3: return v ? 4'hc : 4'h1;
			3'h4: return v ? 4'h0 : 4'h8;
			3'h5: return v ? 4'hc : 4'h0;
			3'h6: return v ? 4'hc : 4'h8;
			3'h7: return v ? 4'h2 : 4'h1;
			default: return 4'h0;
		endcase
	endfunction : exp_gp

	// Expected drive of a usb-capable pin; drive enable overrides the pull
	function automatic logic [3:0] exp_usb(input logic pu, input logic de, input logic v);
		return de ? (v ? 4'hc : 4'h8) : pu ? (v ? 4'h2 : 4'h8) : (v ? 4'h0 : 4'h8);
	endfunction : exp_usb

	// Observed drive of one pin; the value only counts while the driver is on
	function automatic logic [7:0] obs(input int p);
		return {4'h0, pad_oe_out[p], pad_oe_out[p] & pad_out[p], pull_up_out[p], pull_down_out[p]};
	endfunction : obs

	task automatic wrap_up();
		if (error_cnt == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	// One-cycle write strobe
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge mclk_in);
		wr_in <= 1'b0;
	endtask : wr

	// One-cycle read strobe; data is looked at in the single cycle it stands
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		@(posedge mclk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		@(negedge mclk_in);
		chk("rdata", e, rdata_out);
	endtask : rd

	// Registers land at the write edge, pad controls one edge later
	task automatic settle();
		repeat (2) @(negedge mclk_in);
	endtask : settle

	// Bounded wait for the port request
	task automatic wait_irq();
		int i;
		for (i = 0; i < 20 && irq_out !== 1'b1; i++)
			@(negedge mclk_in);
		if (i == 20) begin
			error_cnt++;
			wrap_up();
		end
	endtask : wait_irq

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (12) @(posedge mclk_in);
		arst_n_in <= 1'b1;
		repeat (3) @(negedge mclk_in);
		chk("strap oe", 8'hff, pad_oe_out);
		chk("strap out", 8'h00, pad_out);
		// Every code and both values on pin 0 through its pin-form register
		for (int k = 0; k < 16; k++) begin
			wr(5'h10, {4'h0, k[3:1], k[0]});
			settle();
			chk("drive", {4'h0, exp_gp(k[3:1], k[0])}, obs(0));
		end
		// Pin form reads back the last code and value of pin 0
		rd(5'h10, 8'h0f);
		// Port-form writes reach pins 0..5 and spare the usb pins
		wr(5'h02, 8'hff);
		wr(5'h03, 8'hff);
		wr(5'h04, 8'hff);
		wr(5'h00, 8'hff);
		settle();
		chk("pull up", 8'h3f, pull_up_out);
		chk("oe", 8'h00, pad_oe_out);
		// Port form of drive bit 2 shows the usb pins untouched
		rd(5'h04, 8'h3f);
		// Usb pin 7: every pull, drive enable and value
		for (int k = 0; k < 8; k++) begin
			wr(5'h17, {5'h00, k[2], k[1], k[0]});
			settle();
			chk("usb drive", {4'h0, exp_usb(k[2], k[1], k[0])}, obs(7));
		end
		wr(5'h02, 8'h00);
		settle();
		chk("usb kept", 8'h0c, obs(7));
		@(posedge mclk_in);
		usb_mode_in <= 1'b1;
		settle();
		chk("usb mode", 8'h00, obs(7) | obs(6));
		// Fabric takes over pin 0 while pin 1 keeps the register value
		wr(5'h05, 8'h01);
		settle();
		chk("bypass lo", 8'h0e, {4'h0, pad_oe_out[1:0], pad_out[1:0]});
		@(posedge mclk_in);
		fabric_out_in <= 8'h01;
		settle();
		chk("bypass hi", 8'h0f, {4'h0, pad_oe_out[1:0], pad_out[1:0]});
		wr(5'h05, 8'h00);
		// Pins as inputs, driven from the board
		wr(5'h03, 8'h00);
		wr(5'h04, 8'h00);
		wr(5'h02, 8'h3f);
		ext_oe <= 8'hff;
		ext_val <= 8'ha5;
		wr(5'h00, 8'h5a);
		wr(5'h06, 8'h0f);
		wr(5'h01, 8'h00);
		wr(5'h1f, 8'hff);
		rd(5'h01, 8'ha5);
		rd(5'h00, 8'h5a);
		chk("fabric in", 8'h05, fabric_in_out);
		rd(5'h1f, 8'h00);
		rd(5'h0a, 8'h00);
		// Level passes three flops before it shows on the fabric input
		@(posedge mclk_in);
		ext_val <= 8'h5a;
		repeat (3) @(negedge mclk_in);
		chk("sync early", 8'h05, fabric_in_out);
		@(negedge mclk_in);
		chk("sync late", 8'h0a, fabric_in_out);
		// Edge interrupts: pin 0 rise, pin 1 fall, pin 2 both, pin 3 none
		// Pins fall before any enable is armed, so no status may remain
		@(posedge mclk_in);
		ext_val <= 8'h00;
		wr(5'h07, 8'h05);
		wr(5'h08, 8'h06);
		rd(5'h09, 8'h00);
		@(posedge mclk_in);
		ext_val <= 8'h0f;
		wait_irq();
		rd(5'h09, 8'h05);
		chk("irq clear", 8'h00, {7'h00, irq_out});
		repeat (6) @(negedge mclk_in);
		chk("irq level", 8'h00, {7'h00, irq_out});
		@(posedge mclk_in);
		ext_val <= 8'h00;
		wait_irq();
		rd(5'h09, 8'h06);
		rd(5'h09, 8'h00);
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
